// File: core/mcr_bank.sv
// Summary of operation
// [R1] Memory target codes: none, I, Q, both, map, FIFO
// [R2] Memory control bit 5 selects read direction
// [R3] Bit 6 auto-advances memory address
// [R4] Symbol counter mode uses 16-bit limit
// [R5] Bit 13 bypasses final filter, reset set
// [R6] Bit 12 doubles input rate, halves taps
// [R7] Interpolation 4x/8x/16x, code 11 reserved
// [R8] Width field gives bits minus one, or half
// [R9] Sinc, shaping, map, FIFO bypass bits, reset 1
// [R10] Bit 4 enables half band filter, reset 0
// [R11] Bit 2 enables decimate by two
// [R12] Write to 0x0F loads memory word buffer
// [R13] Word 0x11 holds 19-bit coefficient preload
// [R14] Strobe writes give one-cycle pulses only
// [R15] Ports 0-3 stage, port 4 transfers word
// [R16] Port 5 index, ports 0-3 read bytes
// [R17] Map: word select zero writes top byte
module mcr_bank
    import mcr_pkg::*;
#(
    parameter int MEM_ADDR_W = 8
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Host parallel port, one-cycle strobes
    input wire logic [2:0] port_addr_in,
    input wire logic [7:0] config_data_bus_in,
    input wire logic port_wr_in,
    input wire logic port_rd_in,
    output logic [7:0] config_data_bus_out,
    // Memory readback path
    input wire logic [7:0] mem_rd_byte_in,
    output logic [MEM_ADDR_W-1:0] mem_rd_addr_out,
    output logic [3:0] readback_byte_counter_out,
    // Memory access control
    output logic [2:0] mem_target_out,
    output logic mem_read_dir_out,
    output logic mem_auto_inc_out,
    output logic [1:0] mem_word_sel_out,
    output logic [MEM_WORD_W-1:0] memory_word_buffer_out,
    output logic [MEM_ADDR_W-1:0] memory_target_address_out,
    output logic coeff_i_write_out,
    output logic coeff_q_write_out,
    output logic map_write_out,
    output logic fifo_word_write_out,
    // Datapath configuration
    output logic sym_cnt_mode_out,
    output logic [15:0] symbol_counter_limit_out,
    output logic fast_dac_delay_out,
    output logic final_interp_bypass_out,
    output logic two_bit_mode_out,
    output logic half_taps_out,
    output logic [4:0] interp_factor_out,
    output logic interp_reserved_out,
    output logic [5:0] sample_width_out,
    output logic sinc_bypass_out,
    output logic half_band_enable_out,
    output logic shape_bypass_out,
    output logic decim2_enable_out,
    output logic map_bypass_out,
    output logic fifo_bypass_out,
    // All words raw, and the preload field
    output logic [NUM_CW-1:0][31:0] control_words_out,
    output logic [18:0] coefficient_preload_out,
    // Strobes
    output logic fifo_reset_pulse_out,
    output logic memory_word_load_pulse_out,
    output logic soft_reset_pulse_out,
    output logic fifo_write_pulse_out
);

    if (MEM_ADDR_W < 1 || MEM_ADDR_W > 8) begin : g_addr_w_check
        $error("mcr_bank: MEM_ADDR_W must be 1 to 8");
    end

    typedef struct packed {
        logic [NUM_CW-1:0][31:0] cw;
        logic [31:0] staging_word;
        logic [4:0] readback_word_index;
        logic [MEM_ADDR_W-1:0] mem_rd_addr;
        logic [3:0] readback_byte_counter;
        logic [1:0] word_sel;
        logic [MEM_WORD_W-1:0] memory_word_buffer;
        logic [MEM_ADDR_W-1:0] memory_target_address;
        logic [MEM_ADDR_W-1:0] commit_addr;
        logic coeff_i_write;
        logic coeff_q_write;
        logic map_write;
        logic fifo_word_write;
        logic [7:0] rdata;
    } mcr_state_t;

    mcr_state_t s_r;
    mcr_state_t s_nxt;

    logic xfer;
    logic [4:0] xfer_index;
    logic load_now;
    logic [2:0] target;
    logic [31:0] mem_ctrl;
    logic [31:0] dev_cfg;
    logic [4:0] width_m1;
    logic [NUM_STROBES-1:0] strobes;

    assign xfer = port_wr_in && (port_addr_in == PA_XFER); // [R15]
    assign xfer_index = config_data_bus_in[4:0];
    assign load_now = xfer && (xfer_index == CW_MEM_LOAD); // [R12]
    assign mem_ctrl = s_r.cw[CW_MEM_CTRL];
    assign dev_cfg = s_r.cw[CW_DEV_CFG];
    assign target = mem_ctrl[MC_SEL_LO +: 3];

    always_comb begin
        logic [MEM_ADDR_W-1:0] next_addr;
        next_addr = '0;
        s_nxt = s_r;
        s_nxt.coeff_i_write = 1'b0;
        s_nxt.coeff_q_write = 1'b0;
        s_nxt.map_write = 1'b0;
        s_nxt.fifo_word_write = 1'b0;

        // Auto increment writes the current address then steps it
        if (mem_ctrl[MC_AUTO_INC]) begin
            next_addr = s_r.memory_target_address; // [R3]
        end else begin
            next_addr = s_r.staging_word[24 +: MEM_ADDR_W];
        end

        if (port_wr_in) begin
            if (port_addr_in <= PA_STAGE_TOP) begin
                s_nxt.staging_word[{port_addr_in[1:0], 3'b000} +: 8] = config_data_bus_in; // [R15]
            end else if (port_addr_in == PA_XFER) begin
                if (xfer_index < 5'(NUM_CW)) begin
                    // Strobe words have an empty mask and keep nothing
                    s_nxt.cw[xfer_index] = s_r.staging_word & CW_MASK[xfer_index]; // [R15] [R13] [R14]
                end
                if (xfer_index == CW_MEM_CTRL) begin
                    s_nxt.word_sel = s_r.staging_word[MC_WSEL_LO +: 2];
                end
            end else if (port_addr_in == PA_RB_INDEX) begin
                s_nxt.readback_word_index = config_data_bus_in[4:0]; // [R16]
            end else if (port_addr_in == PA_MEM_RD_ADDR) begin
                s_nxt.mem_rd_addr = config_data_bus_in[MEM_ADDR_W-1:0];
                s_nxt.readback_byte_counter = '0;
            end else begin
                s_nxt.readback_byte_counter = s_r.readback_byte_counter + 4'h1;
            end
        end

        // Read direction leaves buffer and address untouched
        if (load_now && !mem_ctrl[MC_READ]) begin // [R2]
            unique case (target) // [R1]
                MSEL_I_COEFF, MSEL_Q_COEFF, MSEL_IQ_COEFF: begin
                    s_nxt.memory_word_buffer[s_r.word_sel * WORD_SLICE +: WORD_SLICE] =
                        s_r.staging_word[WORD_SLICE-1:0]; // [R12]
                    if (s_r.word_sel == WSEL_LAST) begin
                        s_nxt.word_sel = '0;
                        s_nxt.commit_addr = next_addr;
                        s_nxt.memory_target_address = mem_ctrl[MC_AUTO_INC] ? next_addr + 1'b1 : next_addr; // [R3]
                        s_nxt.coeff_i_write = target[0];
                        s_nxt.coeff_q_write = target[1];
                    end else begin
                        s_nxt.word_sel = s_r.word_sel + 2'h1;
                    end
                end
                MSEL_MAP: begin
                    if (s_r.word_sel == 2'h0) begin
                        s_nxt.memory_word_buffer[MEM_WORD_W-1 -: 8] = s_r.staging_word[23:16]; // [R17]
                        s_nxt.commit_addr = next_addr;
                        s_nxt.memory_target_address = mem_ctrl[MC_AUTO_INC] ? next_addr + 1'b1 : next_addr;
                        s_nxt.map_write = 1'b1; // [R17]
                    end
                end
                MSEL_FIFO: begin
                    s_nxt.memory_word_buffer[31:0] = s_r.staging_word; // [R12]
                    s_nxt.commit_addr = next_addr;
                    s_nxt.memory_target_address = mem_ctrl[MC_AUTO_INC] ? next_addr + 1'b1 : next_addr;
                    s_nxt.fifo_word_write = 1'b1;
                end
                default: begin
                    // No access, or an unused code: load is ignored
                end
            endcase
        end

        if (port_rd_in) begin
            if (port_addr_in <= PA_STAGE_TOP) begin
                if (s_r.readback_word_index < 5'(NUM_CW)) begin
                    s_nxt.rdata = s_r.cw[s_r.readback_word_index][{port_addr_in[1:0], 3'b000} +: 8]; // [R16]
                end else begin
                    s_nxt.rdata = '0;
                end
            end else begin
                s_nxt.rdata = mem_rd_byte_in;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_r <= '0;
            s_r.cw <= CW_RESET; // [R5] [R9] [R10] [R13]
        end else begin
            s_r <= s_nxt;
        end
    end

    mcr_strobe u_strobe (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .xfer_in(xfer),
        .index_in(xfer_index),
        .pulse_out(strobes)
    );

    assign fifo_reset_pulse_out = strobes[0];
    assign memory_word_load_pulse_out = strobes[1];
    assign soft_reset_pulse_out = strobes[2];
    assign fifo_write_pulse_out = strobes[3];

    assign config_data_bus_out = s_r.rdata;
    assign mem_rd_addr_out = s_r.mem_rd_addr;
    assign readback_byte_counter_out = s_r.readback_byte_counter;

    assign mem_target_out = target; // [R1]
    assign mem_read_dir_out = mem_ctrl[MC_READ]; // [R2]
    assign mem_auto_inc_out = mem_ctrl[MC_AUTO_INC];
    assign mem_word_sel_out = s_r.word_sel;
    assign memory_word_buffer_out = s_r.memory_word_buffer;
    assign memory_target_address_out = s_r.commit_addr;
    assign coeff_i_write_out = s_r.coeff_i_write;
    assign coeff_q_write_out = s_r.coeff_q_write;
    assign map_write_out = s_r.map_write;
    assign fifo_word_write_out = s_r.fifo_word_write;

    assign sym_cnt_mode_out = dev_cfg[DC_SYM_CNT_MODE]; // [R4]
    assign symbol_counter_limit_out = dev_cfg[DC_LIMIT_LO +: 16]; // [R4]
    assign fast_dac_delay_out = dev_cfg[DC_FAST_DAC];
    assign final_interp_bypass_out = dev_cfg[DC_FINAL_BYPASS]; // [R5]
    assign two_bit_mode_out = dev_cfg[DC_TWO_BIT]; // [R6]
    assign half_taps_out = dev_cfg[DC_TWO_BIT]; // [R6]
    assign sinc_bypass_out = dev_cfg[DC_SINC_BYPASS]; // [R9]
    assign half_band_enable_out = dev_cfg[DC_HALF_BAND]; // [R10]
    assign shape_bypass_out = dev_cfg[DC_SHAPE_BYPASS]; // [R9]
    assign decim2_enable_out = dev_cfg[DC_DECIM2]; // [R11]
    assign map_bypass_out = dev_cfg[DC_MAP_BYPASS]; // [R9]
    assign fifo_bypass_out = dev_cfg[DC_FIFO_BYPASS]; // [R9]

    // Width doubles in two-bit mode
    assign width_m1 = {1'b0, dev_cfg[DC_WIDTH_LO +: 4]} + 5'h01;
    assign sample_width_out = dev_cfg[DC_TWO_BIT] ? {width_m1, 1'b0} : {1'b0, width_m1}; // [R8]

    always_comb begin
        interp_reserved_out = 1'b0;
        unique case (dev_cfg[DC_INTERP_LO +: 2]) // [R7]
            INTERP_4X: interp_factor_out = FACTOR_4;
            INTERP_8X: interp_factor_out = FACTOR_8;
            INTERP_16X: interp_factor_out = FACTOR_16;
            default: begin
                // Reserved code: factor reads zero so misuse is visible
                interp_factor_out = '0;
                interp_reserved_out = 1'b1;
            end
        endcase
    end

    assign control_words_out = s_r.cw;
    assign coefficient_preload_out = s_r.cw[CW_COEFF_PRELOAD][18:0]; // [R13]

endmodule : mcr_bank

// File: common/mcr_pkg.sv
package mcr_pkg;

    // Host port addresses
    localparam logic [2:0] PA_STAGE_TOP = 3'h3;
    localparam logic [2:0] PA_XFER = 3'h4;
    localparam logic [2:0] PA_RB_INDEX = 3'h5;
    localparam logic [2:0] PA_MEM_RD_ADDR = 3'h6;
    localparam logic [2:0] PA_MEM_RD_INC = 3'h7;

    // Control word indices
    localparam int NUM_CW = 19;
    localparam logic [4:0] CW_MEM_CTRL = 5'h00;
    localparam logic [4:0] CW_DEV_CFG = 5'h01;
    localparam logic [4:0] CW_FIFO_IO = 5'h02;
    localparam logic [4:0] CW_UPPER_I_GAIN = 5'h03;
    localparam logic [4:0] CW_LOWER_Q_GAIN = 5'h04;
    localparam logic [4:0] CW_GAIN_PHASE = 5'h05;
    localparam logic [4:0] CW_LOOP_FILT = 5'h06;
    localparam logic [4:0] CW_LOCK_PLL = 5'h07;
    localparam logic [4:0] CW_INT_STATUS = 5'h08;
    localparam logic [4:0] CW_INT_ENABLE = 5'h09;
    localparam logic [4:0] CW_CARRIER_FREQ = 5'h0A;
    localparam logic [4:0] CW_SYMBOL_FREQ = 5'h0B;
    localparam logic [4:0] CW_LF_UPPER = 5'h0C;
    localparam logic [4:0] CW_LF_LOWER = 5'h0D;
    localparam logic [4:0] CW_FIFO_RESET = 5'h0E;
    localparam logic [4:0] CW_MEM_LOAD = 5'h0F;
    localparam logic [4:0] CW_SOFT_RESET = 5'h10;
    localparam logic [4:0] CW_COEFF_PRELOAD = 5'h11;
    localparam logic [4:0] CW_FIFO_WRITE = 5'h12;

    // Strobe words, in pulse order
    localparam int NUM_STROBES = 4;
    localparam logic [NUM_STROBES-1:0][4:0] STROBE_INDEX = {CW_FIFO_WRITE, CW_SOFT_RESET, CW_MEM_LOAD, CW_FIFO_RESET};

    // Implemented bits per word, index 0 rightmost
    localparam logic [NUM_CW-1:0][31:0] CW_MASK = {
        32'h0000_0000, 32'h0007_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_00FF,
        32'h0000_00FF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_007F};
    localparam logic [NUM_CW-1:0][31:0] CW_RESET = {
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h8000_0000, 32'h07FF_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0040_0000, 32'h5000_0000, 32'h002F_FFFF, 32'h0000_0002,
        32'hFF00_0002, 32'h0000_0000, 32'h0000_602B, 32'h0000_0000};

    // Memory access control fields
    localparam int MC_AUTO_INC = 6;
    localparam int MC_READ = 5;
    localparam int MC_SEL_LO = 2;
    localparam int MC_WSEL_LO = 0;
    localparam logic [2:0] MSEL_NONE = 3'h0;
    localparam logic [2:0] MSEL_I_COEFF = 3'h1;
    localparam logic [2:0] MSEL_Q_COEFF = 3'h2;
    localparam logic [2:0] MSEL_IQ_COEFF = 3'h3;
    localparam logic [2:0] MSEL_MAP = 3'h4;
    localparam logic [2:0] MSEL_FIFO = 3'h5;
    localparam logic [1:0] WSEL_LAST = 2'h2;

    // Device configuration fields
    localparam int DC_LIMIT_LO = 16;
    localparam int DC_SYM_CNT_MODE = 15;
    localparam int DC_FAST_DAC = 14;
    localparam int DC_FINAL_BYPASS = 13;
    localparam int DC_TWO_BIT = 12;
    localparam int DC_INTERP_LO = 10;
    localparam int DC_WIDTH_LO = 6;
    localparam int DC_SINC_BYPASS = 5;
    localparam int DC_HALF_BAND = 4;
    localparam int DC_SHAPE_BYPASS = 3;
    localparam int DC_DECIM2 = 2;
    localparam int DC_MAP_BYPASS = 1;
    localparam int DC_FIFO_BYPASS = 0;

    localparam logic [1:0] INTERP_4X = 2'h0;
    localparam logic [1:0] INTERP_8X = 2'h1;
    localparam logic [1:0] INTERP_16X = 2'h2;
    localparam logic [4:0] FACTOR_4 = 5'h04;
    localparam logic [4:0] FACTOR_8 = 5'h08;
    localparam logic [4:0] FACTOR_16 = 5'h10;

    localparam int WORD_SLICE = 24;
    localparam int MEM_WORD_W = 72;

endpackage : mcr_pkg

// File: core/mcr_strobe.sv
module mcr_strobe
    import mcr_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Transfer request
    input wire logic xfer_in,
    input wire logic [4:0] index_in,
    // Pulses, order as STROBE_INDEX
    output logic [NUM_STROBES-1:0] pulse_out
);

    logic [NUM_STROBES-1:0] pulse_r;
    logic [NUM_STROBES-1:0] pulse_nxt;

    // Registered from the transfer, not held: each pulse lasts one cycle
    genvar gi;
    generate
        for (gi = 0; gi < NUM_STROBES; gi++) begin : g_strobe
            assign pulse_nxt[gi] = xfer_in && (index_in == STROBE_INDEX[gi]); // [R14]
        end
    endgenerate

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pulse_r <= '0;
        end else begin
            pulse_r <= pulse_nxt;
        end
    end

    assign pulse_out = pulse_r;

endmodule : mcr_strobe

// File: verification/mcr_bank_monitor.sv
module mcr_bank_monitor
    import mcr_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Host port
    input wire logic [2:0] port_addr_in,
    input wire logic [7:0] config_data_bus_in,
    input wire logic port_wr_in,
    // Memory access
    input wire logic [2:0] mem_target_out,
    input wire logic mem_read_dir_out,
    input wire logic [1:0] mem_word_sel_out,
    input wire logic [MEM_WORD_W-1:0] memory_word_buffer_out,
    input wire logic map_write_out,
    // Configuration
    input wire logic [15:0] symbol_counter_limit_out,
    input wire logic final_interp_bypass_out,
    input wire logic interp_reserved_out,
    input wire logic [5:0] sample_width_out,
    input wire logic sinc_bypass_out,
    input wire logic shape_bypass_out,
    input wire logic map_bypass_out,
    input wire logic fifo_bypass_out,
    input wire logic [NUM_CW-1:0][31:0] control_words_out,
    input wire logic [18:0] coefficient_preload_out,
    // Strobes
    input wire logic fifo_reset_pulse_out,
    input wire logic memory_word_load_pulse_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);
    logic xfer;
    logic [4:0] idx;
    logic [31:0] cfg;
    assign xfer = port_wr_in && port_addr_in == PA_XFER;
    assign idx = config_data_bus_in[4:0];
    assign cfg = control_words_out[CW_DEV_CFG];

    load_pulse_a: assert property (xfer && idx == CW_MEM_LOAD |=> memory_word_load_pulse_out)
        else $error("load pulse missing");
    fifo_rst_pulse_a: assert property (fifo_reset_pulse_out
        |-> $past(xfer && idx == CW_FIFO_RESET) ##1 !fifo_reset_pulse_out)
        else $error("fifo reset pulse wrong");
    read_hold_a: assert property (xfer && idx == CW_MEM_LOAD && mem_read_dir_out
        |=> $stable(memory_word_buffer_out) [*2])
        else $error("buffer changed on read");
    map_commit_a: assert property (xfer && idx == CW_MEM_LOAD && !mem_read_dir_out
        && mem_target_out == MSEL_MAP && mem_word_sel_out == 2'h0 |-> ##[1:2] map_write_out)
        else $error("map write missing");
    limit_field_a: assert property (symbol_counter_limit_out == cfg[31:16])
        else $error("symbol limit mismatch");
    final_bypass_a: assert property (final_interp_bypass_out == cfg[DC_FINAL_BYPASS])
        else $error("final bypass mismatch");
    bypass_bits_a: assert property ({sinc_bypass_out, shape_bypass_out, map_bypass_out, fifo_bypass_out}
        == {cfg[5], cfg[3], cfg[1], cfg[0]})
        else $error("bypass bits mismatch");
    interp_resv_a: assert property (interp_reserved_out == (cfg[11:10] == 2'h3))
        else $error("reserved flag mismatch");
    width_map_a: assert property (sample_width_out == (({2'h0, cfg[9:6]} + 6'h01) << cfg[12]))
        else $error("sample width mismatch");
    preload_word_a: assert property ({13'h0, coefficient_preload_out}
        == control_words_out[CW_COEFF_PRELOAD])
        else $error("preload mismatch");
endmodule : mcr_bank_monitor

bind mcr_bank mcr_bank_monitor u_mon (.mclk_in, .resetn_in, .port_addr_in, .config_data_bus_in, .port_wr_in,
    .mem_target_out, .mem_read_dir_out, .mem_word_sel_out, .memory_word_buffer_out, .map_write_out,
    .symbol_counter_limit_out, .final_interp_bypass_out, .interp_reserved_out, .sample_width_out,
    .sinc_bypass_out, .shape_bypass_out, .map_bypass_out, .fifo_bypass_out, .control_words_out,
    .coefficient_preload_out, .fifo_reset_pulse_out, .memory_word_load_pulse_out);

// File: verification/mcr_host.sv
module mcr_host
    import mcr_pkg::*;
(
    // Clock
    input wire logic mclk_in,
    // Parallel port
    output logic [2:0] port_addr_out,
    output logic [7:0] data_out,
    output logic wr_out,
    output logic rd_out,
    input wire logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        port_addr_out = 3'h0;
        data_out = 8'h00;
        wr_out = 1'h0;
        rd_out = 1'h0;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        port_addr_out <= a;
        data_out <= d;
        wr_out <= 1'h1;
        @(posedge mclk_in);
        wr_out <= 1'h0;
        // Released bus shows the inverse so a stale byte cannot pass
        data_out <= ~d;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        port_addr_out <= a;
        rd_out <= 1'h1;
        @(posedge mclk_in);
        rd_out <= 1'h0;
        #1 d = data_in;
    endtask : rd
    task automatic put_word(input logic [4:0] idx, input logic [31:0] v);
        for (int i = 0; i < 4; i++) begin
            wr(3'(i), v[8*i+:8]);
        end
        wr(PA_XFER, {3'h0, idx});
    endtask : put_word
    task automatic get_word(input logic [4:0] idx, output logic [31:0] v);
        logic [7:0] b;
        wr(PA_RB_INDEX, {3'h0, idx});
        for (int i = 0; i < 4; i++) begin
            rd(3'(i), b);
            v[8*i+:8] = b;
        end
    endtask : get_word
endmodule : mcr_host

// File: verification/tb.sv
module tb
    import mcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 1'h0;
    logic resetn_in = 1'h0;
    logic [2:0] port_addr_in, mem_target_out;
    logic [7:0] config_data_bus_in, config_data_bus_out, mem_rd_byte_in, mem_rd_addr_out, memory_target_address_out;
    logic port_wr_in, port_rd_in, mem_read_dir_out, mem_auto_inc_out, sym_cnt_mode_out, final_interp_bypass_out;
    logic half_taps_out, interp_reserved_out, sinc_bypass_out, half_band_enable_out, shape_bypass_out;
    logic decim2_enable_out, map_bypass_out, fifo_bypass_out, fast_dac_delay_out, two_bit_mode_out;
    logic [3:0] readback_byte_counter_out;
    logic [MEM_WORD_W-1:0] memory_word_buffer_out;
    logic [15:0] symbol_counter_limit_out;
    logic [4:0] interp_factor_out;
    logic [5:0] sample_width_out;
    logic [18:0] coefficient_preload_out;
    logic [7:0] pv;
    int pcnt [8];
    int snap [8];
    int n_mismatch = 0;
    int total_checks = 0;
    // Readback memory: byte depends on address and byte number
    assign mem_rd_byte_in = mem_rd_addr_out ^ {4'h5, readback_byte_counter_out};
    initial begin
        forever #20 mclk_in = ~mclk_in;
    end
    mcr_host HOST (.mclk_in, .port_addr_out(port_addr_in), .data_out(config_data_bus_in), .wr_out(port_wr_in),
        .rd_out(port_rd_in), .data_in(config_data_bus_out));
    mcr_bank DUT (.mclk_in, .resetn_in, .port_addr_in, .config_data_bus_in, .port_wr_in, .port_rd_in,
        .config_data_bus_out, .mem_rd_byte_in, .mem_rd_addr_out, .readback_byte_counter_out, .mem_target_out,
        .mem_read_dir_out, .mem_auto_inc_out, .mem_word_sel_out(), .memory_word_buffer_out,
        .memory_target_address_out, .coeff_i_write_out(pv[4]), .coeff_q_write_out(pv[5]), .map_write_out(pv[6]),
        .fifo_word_write_out(pv[7]), .sym_cnt_mode_out, .symbol_counter_limit_out, .fast_dac_delay_out,
        .final_interp_bypass_out, .two_bit_mode_out, .half_taps_out, .interp_factor_out, .interp_reserved_out,
        .sample_width_out, .sinc_bypass_out, .half_band_enable_out, .shape_bypass_out, .decim2_enable_out,
        .map_bypass_out, .fifo_bypass_out, .control_words_out(), .coefficient_preload_out,
        .fifo_reset_pulse_out(pv[0]), .memory_word_load_pulse_out(pv[1]), .soft_reset_pulse_out(pv[2]),
        .fifo_write_pulse_out(pv[3]));
    always @(posedge mclk_in) begin
        for (int i = 0; i < 8; i++) begin
            pcnt[i] <= pcnt[i] + int'(pv[i] === 1'h1);
        end
    end
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Quiet period first, so late pulses of earlier writes are not counted
    task automatic grab;
        repeat (4) @(posedge mclk_in);
        snap = pcnt;
    endtask : grab
    task automatic chk_pulses(input logic [7:0] exp);
        for (int i = 0; i < 8; i++) begin
            chk(72'(pcnt[i] - snap[i]), 72'(exp[i]));
        end
    endtask : chk_pulses
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic t_reset;
        logic [31:0] v;
        chk({fast_dac_delay_out, final_interp_bypass_out, sinc_bypass_out, half_band_enable_out, shape_bypass_out,
            decim2_enable_out, map_bypass_out, fifo_bypass_out}, 8'hEB);
        for (int i = 0; i < NUM_CW; i++) begin
            HOST.get_word(5'(i), v);
            chk(v, CW_RESET[i]);
        end
        HOST.get_word(5'h13, v);
        chk(v, 32'h0000_0000);
    endtask : t_reset
    task automatic t_cfg;
        logic [31:0] w, v;
        logic [4:0] fac [4] = '{5'h04, 5'h08, 5'h10, 5'h00};
        for (int c = 0; c < 4; c++) begin
            w = {16'hA55A, 3'h4, c[0], 2'(c), 4'hF, 6'h14};
            HOST.put_word(CW_DEV_CFG, w);
            HOST.get_word(CW_DEV_CFG, v);
            chk(v, w);
            chk({sym_cnt_mode_out, symbol_counter_limit_out}, {1'h1, 16'hA55A});
            chk({two_bit_mode_out, half_taps_out}, {2{c[0]}});
            chk({interp_reserved_out, interp_factor_out}, {c == 3, fac[c]});
            chk(sample_width_out, c[0] ? 6'h20 : 6'h10);
            chk({half_band_enable_out, decim2_enable_out, sinc_bypass_out, shape_bypass_out, map_bypass_out,
                fifo_bypass_out, final_interp_bypass_out}, 7'h60);
        end
    endtask : t_cfg
    task automatic t_mem_ctrl;
        logic [31:0] v;
        for (int t = 0; t < 6; t++) begin
            HOST.put_word(CW_MEM_CTRL, {25'h0, t[0], t[1], 3'(t), 2'h0});
            HOST.get_word(CW_MEM_CTRL, v);
            chk({mem_auto_inc_out, mem_read_dir_out, mem_target_out}, {t[0], t[1], 3'(t)});
        end
        HOST.put_word(CW_MEM_CTRL, 32'h0000_0080);
        HOST.get_word(CW_MEM_CTRL, v);
        chk(v, 32'h0000_0000);
    endtask : t_mem_ctrl
    task automatic t_strobe;
        logic [31:0] v;
        for (int s = 0; s < NUM_STROBES; s++) begin
            grab();
            HOST.put_word(STROBE_INDEX[s], 32'hFFFF_FFFF);
            HOST.get_word(STROBE_INDEX[s], v);
            chk(v, 32'h0000_0000);
            chk_pulses(8'(1 << s));
        end
    endtask : t_strobe
    task automatic t_load;
        logic [31:0] v;
        logic [7:0] a1;
        HOST.put_word(CW_MEM_CTRL, 32'h0000_000C);
        HOST.put_word(CW_MEM_LOAD, 32'h0011_1111);
        HOST.put_word(CW_MEM_LOAD, 32'h0022_2222);
        grab();
        HOST.put_word(CW_MEM_LOAD, 32'h1233_3333);
        HOST.get_word(CW_MEM_CTRL, v);
        chk(memory_word_buffer_out, 72'h33_3333_2222_2211_1111);
        chk(memory_target_address_out, 8'h12);
        chk_pulses(8'h32);
        HOST.put_word(CW_MEM_CTRL, 32'h0000_0050);
        grab();
        HOST.put_word(CW_MEM_LOAD, 32'h00A5_0000);
        HOST.get_word(CW_MEM_CTRL, v);
        chk(memory_word_buffer_out[71:64], 8'hA5);
        chk_pulses(8'h42);
        a1 = memory_target_address_out;
        HOST.put_word(CW_MEM_LOAD, 32'h00A5_0000);
        HOST.get_word(CW_MEM_CTRL, v);
        chk(memory_target_address_out, a1 + 8'h01);
        HOST.put_word(CW_MEM_CTRL, 32'h0000_0010);
        HOST.put_word(CW_MEM_LOAD, 32'h335A_0000);
        HOST.get_word(CW_MEM_CTRL, v);
        chk({memory_target_address_out, memory_word_buffer_out[71:64]}, 16'h335A);
        HOST.put_word(CW_MEM_CTRL, 32'h0000_0030);
        grab();
        HOST.put_word(CW_MEM_LOAD, 32'h0077_0000);
        HOST.get_word(CW_MEM_CTRL, v);
        chk(memory_word_buffer_out[71:64], 8'h5A);
        chk_pulses(8'h02);
        HOST.put_word(CW_MEM_CTRL, 32'h0000_0014);
        grab();
        HOST.put_word(CW_MEM_LOAD, 32'h8765_4321);
        HOST.get_word(CW_MEM_CTRL, v);
        chk({memory_target_address_out, memory_word_buffer_out[31:0]}, 40'h87_8765_4321);
        chk_pulses(8'h82);
        HOST.put_word(CW_MEM_CTRL, 32'h0000_0000);
    endtask : t_load
    task automatic t_preload;
        logic [31:0] v;
        logic [7:0] b;
        HOST.put_word(CW_COEFF_PRELOAD, 32'hFFFF_FFFF);
        HOST.get_word(CW_COEFF_PRELOAD, v);
        chk(v, 32'h0007_FFFF);
        chk(coefficient_preload_out, 19'h7_FFFF);
        HOST.wr(PA_MEM_RD_ADDR, 8'h12);
        HOST.wr(PA_MEM_RD_INC, 8'h00);
        HOST.rd(PA_XFER, b);
        chk(b, 8'h43);
    endtask : t_preload
    initial begin
        repeat (3) @(posedge mclk_in);
        resetn_in <= 1'h1;
        t_reset();
        t_cfg();
        t_mem_ctrl();
        t_strobe();
        t_load();
        t_preload();
        print_verdict();
    end
    initial begin
        repeat (40000) @(posedge mclk_in);
        n_mismatch++;
        print_verdict();
    end
endmodule : tb
